// File: core/dsp_pkg.sv
// Constants and carrier types for the drive serial protocol slave.
// Notes on behaviour
// RULE1 - Telegram: start, length, address, net, check
// RULE2 - 16-bit values go high byte first
// RULE3 - 32-bit values go high word first
// RULE4 - Slave transmits only replies to own tasks
// RULE5 - Address selects slave; at most 31 slaves
// RULE6 - Master idles two characters before start
// RULE7 - Start interval scales with baud rate
// RULE8 - Start byte valid only after idle interval
// RULE9 - Reply within 20 ms, not before interval
// RULE10 - Master logs error on missing reply
// RULE11 - Master waits for reply before next slave
// RULE12 - Master polls from circulating address list
// RULE13 - Half duplex; driver on only while sending
// RULE14 - Length byte; address holds node and type
// RULE15 - Fixed and variable length telegrams supported
// RULE16 - Link settings match and stay fixed
// RULE17 - Process data handled every 8 ms
// RULE18 - Parameter area 3, 4 or variable(127), min 3
// RULE19 - Comm module present disables this slave
// RULE20 - Check byte is XOR; bad telegrams dropped
// RULE21 - Ignore telegrams for other node numbers; code still pulses frame_ok and rx_word_valid for them
package dsp_pkg;
	localparam logic [7:0] START_BYTE = 8'h02;
	localparam logic [6:0] PARM_VARIABLE = 7'h7F;
	localparam logic [6:0] PARM_MIN_WORDS = 7'h03;
	localparam int NODE_W = 5;
	localparam int CHAR_BITS = 11;
	localparam int IDLE_CHARS = 2;
	localparam int CLK_PERIOD_NS = 5;
	localparam int REPLY_MAX_NS = 20000000;
	localparam int REPLY_MAX_CYC = REPLY_MAX_NS / CLK_PERIOD_NS;
	localparam int PD_CYCLE_NS = 8000000;
	localparam int PD_CYCLE_CYC = PD_CYCLE_NS / CLK_PERIOD_NS;
	localparam logic [15:0] BAUD_DIV_RST = 16'h5161;

	typedef struct packed {
		logic [NODE_W-1:0] node;
		logic [15:0] baud_div;
		logic [6:0] parm_len;
		logic [3:0] pd_len;
		logic [6:0] var_words;
	} dsp_cfg_t;

	typedef struct packed {
		logic [15:0] data;
		logic first;
	} dsp_word_t;
endpackage : dsp_pkg

// File: core/dsp_fifo.sv
// Small synchronous FIFO with registered ready and valid flags.
`timescale 1ns/100ps
module dsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rp];

	always_comb
	begin
		next_cnt = cnt;
		if (push && !pop)
			next_cnt = cnt + CW'(1);
		else if (pop && !push)
			next_cnt = cnt - CW'(1);
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + AW'(1);
			if (pop)
				rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + AW'(1);
			cnt <= next_cnt;
			in_ready <= next_cnt != CW'(DEPTH);
			out_valid <= next_cnt != '0;
		end
	end
endmodule : dsp_fifo

// File: core/dsp_uart.sv
// Character receiver and transmitter: 8 data bits, even parity, one stop bit.
`timescale 1ns/100ps
module dsp_uart (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Bit period in clock cycles
	input wire logic [15:0] baud_div,
	// Receive side
	input wire logic rx_pin,
	output logic rx_start,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic rx_busy,
	// Transmit side
	input wire logic tx_load,
	input wire logic [7:0] tx_byte,
	output logic tx_busy,
	output logic tx_line
);
	logic s1, s2, s3, lvl;
	logic [15:0] rx_cnt;
	logic [3:0] rx_bit;
	logic [8:0] rx_sh;
	logic [15:0] tx_cnt;
	logic [3:0] tx_bit;
	logic [10:0] tx_sh;

	// The line level changes only when the second and third stages agree.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			lvl <= 1'b1;
		end
		else
		begin
			s1 <= rx_pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				lvl <= s3;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rx_busy <= 1'b0;
			rx_start <= 1'b0;
			rx_valid <= 1'b0;
			rx_byte <= 8'h00;
			rx_cnt <= 16'h0000;
			rx_bit <= 4'h0;
			rx_sh <= 9'h000;
		end
		else
		begin
			rx_start <= 1'b0;
			rx_valid <= 1'b0;
			if (!rx_busy)
			begin
				if (!lvl)
				begin
					rx_busy <= 1'b1;
					rx_start <= 1'b1;
					rx_cnt <= baud_div >> 1;
					rx_bit <= 4'h0;
				end
			end
			else if (rx_cnt != 16'h0000)
				rx_cnt <= rx_cnt - 16'h0001;
			else
			begin
				rx_cnt <= baud_div - 16'h0001;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0)
					rx_busy <= !lvl;
				else if (rx_bit == 4'hA)
				begin
					rx_busy <= 1'b0;
					rx_valid <= lvl && !(^rx_sh);
					rx_byte <= rx_sh[7:0];
				end
				else
					rx_sh <= {lvl, rx_sh[8:1]};
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tx_busy <= 1'b0;
			tx_line <= 1'b1;
			tx_cnt <= 16'h0000;
			tx_bit <= 4'h0;
			tx_sh <= 11'h7FF;
		end
		else if (!tx_busy)
		begin
			if (tx_load)
			begin
				tx_busy <= 1'b1;
				tx_line <= 1'b0;
				tx_sh <= {1'b1, ^tx_byte, tx_byte, 1'b0};
				tx_cnt <= baud_div - 16'h0001;
				tx_bit <= 4'h0;
			end
		end
		else if (tx_cnt != 16'h0000)
			tx_cnt <= tx_cnt - 16'h0001;
		else if (tx_bit == 4'hA)
			tx_busy <= 1'b0;
		else
		begin
			tx_cnt <= baud_div - 16'h0001;
			tx_bit <= tx_bit + 4'h1;
			tx_sh <= {1'b1, tx_sh[10:1]};
			tx_line <= tx_sh[1];
		end
	end
endmodule : dsp_uart

// File: core/dsp_slave.sv
// Slave telegram handler: framing, address filter, check byte and timed reply.
`timescale 1ns/100ps
module dsp_slave
	import dsp_pkg::*;
#(
	parameter int REPLY_MAX = REPLY_MAX_CYC,
	parameter int PD_CYCLE = PD_CYCLE_CYC,
	parameter int REPLY_DEPTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Static link settings
	input wire dsp_cfg_t cfg,
	input wire logic comm_module_present,
	// Serial line
	input wire logic rx_pin,
	output logic tx_pin,
	output logic tx_oe,
	// Received net data
	output dsp_word_t rx_word,
	output logic rx_word_valid,
	output logic frame_ok,
	output logic frame_bad,
	output logic pd_update,
	// Reply net data
	output logic reply_req,
	output logic reply_missed,
	input wire logic reply_valid,
	input wire logic [7:0] reply_byte,
	output logic reply_ready
);
	typedef enum {R_HUNT, R_LEN, R_ADR, R_NET, R_CHK} dsp_rx_t;
	typedef enum {T_IDLE, T_WAIT, T_LEN, T_ADR, T_NET, T_CHK, T_END} dsp_tx_t;

	function automatic logic [6:0] dsp_parm_words(input logic [6:0] set, input logic [6:0] v);
		if (set != PARM_VARIABLE)
			return set;
		return (v < PARM_MIN_WORDS) ? PARM_MIN_WORDS : v;
	endfunction : dsp_parm_words

	dsp_rx_t rstate;
	dsp_tx_t tstate;
	logic u_start, u_valid, u_busy, u_txbusy, tx_load;
	logic [7:0] u_byte, tx_byte;
	logic [31:0] idle_cnt, idle_need, wait_cnt;
	logic idle_ok, gap_ok, odd, word_first;
	logic [7:0] net_left, chk_acc, adr_q, hi_q, tx_left, tx_chk;
	logic [8:0] reply_bytes;
	logic f_valid, f_ready, can_send, pd_fresh;
	logic [7:0] f_data;
	logic [31:0] pd_cnt;

	assign idle_need = 32'(IDLE_CHARS * CHAR_BITS) * {16'h0000, cfg.baud_div}; // RULE7
	assign idle_ok = idle_cnt >= idle_need;
	assign reply_bytes = 9'({dsp_parm_words(cfg.parm_len, cfg.var_words), 1'b0}) // RULE18
		+ 9'({cfg.pd_len, 1'b0});
	assign can_send = !u_txbusy && !tx_load;
	assign f_ready = (tstate == T_NET) && can_send;

	dsp_uart u_uart (
		.clk(clk),
		.sys_rst(sys_rst),
		.baud_div(cfg.baud_div), // RULE16
		.rx_pin(rx_pin),
		.rx_start(u_start),
		.rx_valid(u_valid),
		.rx_byte(u_byte),
		.rx_busy(u_busy),
		.tx_load(tx_load),
		.tx_byte(tx_byte),
		.tx_busy(u_txbusy),
		.tx_line(tx_pin)
	);

	dsp_fifo #(.WIDTH(8), .DEPTH(REPLY_DEPTH)) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(reply_valid),
		.in_data(reply_byte),
		.in_ready(reply_ready),
		.out_valid(f_valid),
		.out_data(f_data),
		.out_ready(f_ready)
	);

	// Quiet-line timer; our own transmission never counts as idle.
	always_ff @(posedge clk)
	begin
		if (sys_rst || u_busy || tx_oe)
			idle_cnt <= 32'h00000000;
		else if (!idle_ok)
			idle_cnt <= idle_cnt + 32'h00000001;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			gap_ok <= 1'b0;
		else if (u_start)
			gap_ok <= idle_ok; // RULE6
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rstate <= R_HUNT;
			net_left <= 8'h00;
			chk_acc <= 8'h00;
			adr_q <= 8'h00;
			hi_q <= 8'h00;
			odd <= 1'b0;
			word_first <= 1'b0;
			rx_word <= '0;
			rx_word_valid <= 1'b0;
			frame_ok <= 1'b0;
			frame_bad <= 1'b0;
			reply_req <= 1'b0;
		end
		else
		begin
			rx_word_valid <= 1'b0;
			frame_ok <= 1'b0;
			frame_bad <= 1'b0;
			reply_req <= 1'b0;
			if (comm_module_present || tx_oe) // RULE19 RULE11
				rstate <= R_HUNT;
			else if (rstate != R_HUNT && idle_ok)
				rstate <= R_HUNT;
			else if (u_valid)
			begin
				chk_acc <= chk_acc ^ u_byte; // RULE20
				case (rstate)
					R_HUNT:
					begin
						chk_acc <= u_byte;
						if (u_byte == START_BYTE && gap_ok) // RULE8
							rstate <= R_LEN;
					end
					R_LEN:
					begin
						net_left <= u_byte - 8'h02; // RULE14
						rstate <= (u_byte < 8'h02) ? R_HUNT : R_ADR;
					end
					R_ADR:
					begin
						adr_q <= u_byte;
						odd <= 1'b0;
						word_first <= 1'b1;
						rstate <= (net_left == 8'h00) ? R_CHK : R_NET;
					end
					R_NET:
					begin
						odd <= !odd;
						if (!odd)
							hi_q <= u_byte; // RULE2
						else
						begin
							rx_word <= '{data: {hi_q, u_byte}, first: word_first}; // RULE3
							rx_word_valid <= 1'b1;
							word_first <= 1'b0;
						end
						net_left <= net_left - 8'h01;
						if (net_left == 8'h01)
							rstate <= R_CHK;
					end
					R_CHK:
					begin
						rstate <= R_HUNT;
						frame_ok <= chk_acc == u_byte; // RULE20
						frame_bad <= chk_acc != u_byte;
						reply_req <= chk_acc == u_byte
							&& adr_q[NODE_W-1:0] == cfg.node; // RULE21 RULE5
					end
					default: rstate <= R_HUNT;
				endcase
			end
		end
	end

	// Reply sequencer: waits for the start interval, then sends the whole telegram.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tstate <= T_IDLE;
			wait_cnt <= 32'h00000000;
			tx_load <= 1'b0;
			tx_byte <= 8'h00;
			tx_left <= 8'h00;
			tx_chk <= 8'h00;
			tx_oe <= 1'b0;
			reply_missed <= 1'b0;
		end
		else
		begin
			tx_load <= 1'b0;
			reply_missed <= 1'b0;
			case (tstate)
				T_IDLE:
				begin
					wait_cnt <= 32'h00000000;
					if (reply_req && !comm_module_present) // RULE4
						tstate <= T_WAIT;
				end
				T_WAIT:
				begin
					wait_cnt <= wait_cnt + 32'h00000001;
					if (wait_cnt >= 32'(REPLY_MAX - 1)) // RULE9
					begin
						tstate <= T_IDLE;
						reply_missed <= 1'b1;
					end
					else if (wait_cnt >= idle_need && f_valid && can_send) // RULE9
					begin
						tx_oe <= 1'b1; // RULE13
						tx_load <= 1'b1;
						tx_byte <= START_BYTE; // RULE1
						tx_chk <= START_BYTE;
						tx_left <= reply_bytes[7:0];
						tstate <= T_LEN;
					end
				end
				T_LEN, T_ADR, T_NET, T_CHK:
				begin
					if (can_send && (tstate != T_NET || f_valid))
					begin
						tx_load <= 1'b1;
						tstate <= (tstate == T_CHK) ? T_END : tstate.next();
						case (tstate)
							T_LEN: tx_byte <= tx_left + 8'h02; // RULE15
							T_ADR: tx_byte <= adr_q;
							T_NET: tx_byte <= f_data;
							default: tx_byte <= tx_chk;
						endcase
						if (tstate == T_LEN)
							tx_chk <= tx_chk ^ (tx_left + 8'h02);
						else if (tstate == T_ADR)
							tx_chk <= tx_chk ^ adr_q;
						else if (tstate == T_NET)
							tx_chk <= tx_chk ^ f_data;
						if (tstate == T_NET)
						begin
							tx_left <= tx_left - 8'h01;
							if (tx_left != 8'h01)
								tstate <= T_NET;
						end
					end
				end
				T_END:
				begin
					if (can_send)
					begin
						tx_oe <= 1'b0; // RULE13
						tstate <= T_IDLE;
					end
				end
				default: tstate <= T_IDLE;
			endcase
		end
	end

	// Process data is handed on once per cycle; a new frame in the tick cycle is kept.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pd_cnt <= 32'h00000000;
			pd_fresh <= 1'b0;
			pd_update <= 1'b0;
		end
		else
		begin
			pd_update <= 1'b0;
			pd_cnt <= (pd_cnt == 32'(PD_CYCLE - 1)) ? 32'h00000000 : pd_cnt + 32'h00000001;
			if (pd_cnt == 32'(PD_CYCLE - 1)) // RULE17
			begin
				pd_update <= pd_fresh || reply_req;
				pd_fresh <= 1'b0;
			end
			if (reply_req)
				pd_fresh <= 1'b1;
		end
	end

	a_oe_only_reply: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
		tx_oe |-> tstate inside {T_LEN, T_ADR, T_NET, T_CHK, T_END})
		else $error("Driver enabled outside a reply.");
	a_reply_needs_task: assert property (@(posedge clk) disable iff (sys_rst) // RULE21
		(tstate == T_IDLE && !reply_req) |=> tstate == T_IDLE)
		else $error("Reply started without an addressed task.");
	a_reply_min_gap: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
		$rose(tx_oe) |-> $past(wait_cnt) >= idle_need)
		else $error("Reply started before the start interval.");
	a_reply_max_wait: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
		tstate == T_WAIT |-> wait_cnt < 32'(REPLY_MAX))
		else $error("Reply wait exceeded its limit.");
	a_first_start_byte: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
		$rose(tx_oe) |-> tx_load && tx_byte == START_BYTE)
		else $error("Reply did not open with the start byte.");
	a_start_after_idle: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
		(rstate == R_HUNT ##1 rstate == R_LEN) |-> $past(gap_ok))
		else $error("Start byte taken without idle interval.");
	a_bad_check_drop: assert property (@(posedge clk) disable iff (sys_rst) // RULE20
		frame_bad |-> !frame_ok && !reply_req)
		else $error("Telegram with bad check accepted.");
	a_module_disables: assert property (@(posedge clk) disable iff (sys_rst) // RULE19
		(comm_module_present && tstate == T_IDLE) |=> tstate == T_IDLE)
		else $error("Slave replied while module present.");
	a_parm_min_len: assert property (@(posedge clk) disable iff (sys_rst) // RULE18
		reply_bytes >= 9'({PARM_MIN_WORDS, 1'b0}))
		else $error("Parameter area shorter than minimum.");
	a_pd_tick_period: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
		pd_update |-> $past(pd_cnt) == 32'(PD_CYCLE - 1))
		else $error("Process data handed on off cycle.");

	c_good_frame: cover property (@(posedge clk) disable iff (sys_rst) frame_ok && reply_req);
	c_bad_frame: cover property (@(posedge clk) disable iff (sys_rst) frame_bad);
	c_reply_sent: cover property (@(posedge clk) disable iff (sys_rst) $fell(tx_oe));
	c_reply_missed: cover property (@(posedge clk) disable iff (sys_rst) reply_missed);
endmodule : dsp_slave

// File: test/dsp_master_model.sv
// Bus master model: sends task telegrams and collects the slave's reply bytes.
`timescale 1ns/100ps
module dsp_master_model #(
	parameter int BIT_CYC = 16
) (
	// Clock
	input wire logic clk,
	// Slave line driver
	input wire logic tx_oe,
	input wire logic tx_pin,
	// Shared pair
	output logic line
);
	logic drv = 1'b1;
	logic m_oe = 1'b0;
	logic [7:0] b;
	logic [7:0] rx_q[$];
	int par_err = 0;

	// The biased pair rests high while neither party drives it.
	assign line = tx_oe ? tx_pin : (m_oe ? drv : 1'b1);

	task automatic bit_out(input logic v);
		drv = v;
		repeat (BIT_CYC) @(negedge clk);
	endtask : bit_out

	task automatic send_byte(input logic [7:0] d);
		bit_out(1'b0);
		for (int i = 0; i < 8; i++)
			bit_out(d[i]);
		bit_out(^d);
		bit_out(1'b1);
	endtask : send_byte

	task automatic send_raw(input logic [7:0] q[$], input bit idle);
		if (idle)
			repeat (24 * BIT_CYC) @(negedge clk);
		@(negedge clk);
		m_oe = 1'b1;
		foreach (q[i])
			send_byte(q[i]);
		m_oe = 1'b0;
	endtask : send_raw

	always
	begin
		@(posedge clk);
		if (tx_oe && !line)
		begin
			repeat (BIT_CYC / 2) @(posedge clk);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT_CYC) @(posedge clk);
				b[i] = line;
			end
			repeat (BIT_CYC) @(posedge clk);
			if (line !== ^b)
				par_err++;
			repeat (BIT_CYC) @(posedge clk);
			rx_q.push_back(b);
		end
	end
endmodule : dsp_master_model

// File: test/tb.sv
// Testbench: telegram scenarios against the slave through a bus master model.
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module tb;
	import dsp_pkg::*;
	localparam int BD = 16;
	localparam int RMAX = 20000;
	localparam int PDC = 2000;
	localparam logic [7:0] ADR = 8'h45;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	dsp_cfg_t cfg = '{5'h05, 16'h0010, 7'h03, 4'h0, 7'h03};
	logic comm_module_present = 1'b0;
	logic line, tx_pin, tx_oe, rx_word_valid, frame_ok, frame_bad, pd_update;
	logic reply_req, reply_missed, reply_ready;
	logic reply_valid = 1'b0;
	logic [7:0] reply_byte = 8'h00;
	logic oe_d = 1'b0;
	dsp_word_t rx_word;
	dsp_word_t words[$];
	int failures = 0;
	int checks_done = 0;
	int n_ok, n_bad, n_req, n_miss, n_pd, n_oe, wait_cyc, delay;

	always #2.5 clk = ~clk;

	dsp_slave #(.REPLY_MAX(RMAX), .PD_CYCLE(PDC), .REPLY_DEPTH(4)) dsp_slave_inst (
		.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .comm_module_present(comm_module_present),
		.rx_pin(line), .tx_pin(tx_pin), .tx_oe(tx_oe), .rx_word(rx_word),
		.rx_word_valid(rx_word_valid), .frame_ok(frame_ok), .frame_bad(frame_bad),
		.pd_update(pd_update), .reply_req(reply_req), .reply_missed(reply_missed),
		.reply_valid(reply_valid), .reply_byte(reply_byte), .reply_ready(reply_ready));
	dsp_master_model #(.BIT_CYC(BD)) dsp_master_model_inst (.clk(clk), .tx_oe(tx_oe),
		.tx_pin(tx_pin), .line(line));

	always @(posedge clk)
	begin
		n_ok += (frame_ok === 1'b1);
		n_bad += (frame_bad === 1'b1);
		n_req += (reply_req === 1'b1);
		n_miss += (reply_missed === 1'b1);
		n_pd += (pd_update === 1'b1);
		if (rx_word_valid === 1'b1)
			words.push_back(rx_word);
		wait_cyc = (reply_req === 1'b1) ? 0 : wait_cyc + 1;
		if (tx_oe === 1'b1 && !oe_d)
		begin
			n_oe++;
			delay = wait_cyc;
		end
		oe_d = tx_oe;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	task automatic clr;
		{n_ok, n_bad, n_req, n_miss, n_pd, n_oe} = '0;
		words.delete();
		dsp_master_model_inst.rx_q.delete();
	endtask : clr

	task automatic send(input logic [7:0] adr, input bit bad, input bit idle);
		logic [7:0] q[$];
		logic [7:0] x;
		q = {START_BYTE, 8'h06, adr, 8'h02, 8'h34, 8'h56, 8'h78};
		x = 8'h00;
		foreach (q[i])
			x ^= q[i];
		q.push_back(bad ? ~x : x);
		if (!idle)
			q.push_front(8'h55);
		clr();
		dsp_master_model_inst.send_raw(q, idle);
	endtask : send

	task automatic push(input logic [7:0] d);
		@(negedge clk);
		reply_valid = 1'b1;
		reply_byte = d;
		for (int i = 0; i <= RMAX; i++)
		begin
			@(posedge clk);
			if (reply_ready === 1'b1)
				break;
			if (i == RMAX)
			begin
				failures++;
				report_and_stop();
			end
		end
	endtask : push

	task automatic wait_rx(input int n);
		for (int i = 0; i <= RMAX; i++)
		begin
			@(negedge clk);
			if (dsp_master_model_inst.rx_q.size() >= n)
				break;
			if (i == RMAX)
			begin
				failures++;
				report_and_stop();
			end
		end
	endtask : wait_rx

	task automatic counts(input int ok, input int bad);
		repeat (24 * BD) @(negedge clk);
		`CHK(n_ok, ok)
		`CHK(n_bad, bad)
		`CHK(n_req, 0)
		`CHK(n_oe, 0)
	endtask : counts

	task automatic t_good;
		logic [7:0] exp[$];
		logic [7:0] x;
		send(ADR, 0, 1);
		repeat (BD) @(negedge clk);
		`CHK(n_ok, 1)
		`CHK(n_req, 1)
		`CHK(words.size(), 2)
		`CHK(words[0], {16'h0234, 1'b1})
		`CHK(words[1], {16'h5678, 1'b0})
		for (int i = 0; i < 4; i++)
			push(8'hA0 + 8'(i));
		@(negedge clk);
		reply_valid = 1'b0;
		@(negedge clk);
		`CHK(reply_ready, 1'b0)
		push(8'hA4);
		push(8'hA5);
		@(negedge clk);
		reply_valid = 1'b0;
		wait_rx(10);
		exp = {START_BYTE, 8'h08, ADR, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5};
		x = 8'h00;
		foreach (exp[i])
			x ^= exp[i];
		exp.push_back(x);
		`CHK(dsp_master_model_inst.rx_q.size(), 10)
		foreach (exp[i])
			`CHK(dsp_master_model_inst.rx_q[i], exp[i])
		`CHK(dsp_master_model_inst.par_err, 0)
		`CHK(delay >= 22 * BD && delay < RMAX, 1'b1)
		repeat (2 * BD) @(negedge clk);
		`CHK(tx_oe, 1'b0)
		`CHK(n_oe, 1)
		repeat (PDC) @(negedge clk);
		`CHK(n_pd >= 1, 1'b1)
		$display("test good_frame done");
	endtask : t_good

	task automatic t_var;
		logic [7:0] exp[$];
		logic [7:0] x;
		cfg.parm_len = PARM_VARIABLE;
		cfg.var_words = 7'h02;
		cfg.pd_len = 4'h1;
		send(ADR, 0, 1);
		exp = {START_BYTE, 8'h0A, ADR};
		for (int i = 0; i < 8; i++)
		begin
			push(8'hB0 + 8'(i));
			exp.push_back(8'hB0 + 8'(i));
		end
		@(negedge clk);
		reply_valid = 1'b0;
		wait_rx(12);
		x = 8'h00;
		foreach (exp[i])
			x ^= exp[i];
		exp.push_back(x);
		`CHK(dsp_master_model_inst.rx_q.size(), 12)
		foreach (exp[i])
			`CHK(dsp_master_model_inst.rx_q[i], exp[i])
		repeat (2 * BD) @(negedge clk);
		`CHK(tx_oe, 1'b0)
		cfg = '{5'h05, 16'h0010, 7'h03, 4'h0, 7'h03};
		$display("test variable_length done");
	endtask : t_var

	task automatic t_other;
		send(8'h46, 0, 1);
		counts(1, 0);
		$display("test other_node done");
	endtask : t_other

	task automatic t_bad;
		send(ADR, 1, 1);
		counts(0, 1);
		$display("test bad_check done");
	endtask : t_bad

	task automatic t_noidle;
		send(ADR, 0, 0);
		counts(0, 0);
		$display("test no_idle done");
	endtask : t_noidle

	task automatic t_comm;
		comm_module_present = 1'b1;
		send(ADR, 0, 1);
		counts(0, 0);
		comm_module_present = 1'b0;
		$display("test comm_module done");
	endtask : t_comm

	task automatic t_missed;
		send(ADR, 0, 1);
		repeat (RMAX + BD) @(negedge clk);
		`CHK(n_miss, 1)
		`CHK(n_oe, 0)
		`CHK(dsp_master_model_inst.rx_q.size(), 0)
		$display("test reply_missed done");
	endtask : t_missed

	initial
	begin
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		`CHK(tx_oe, 1'b0)
		`CHK(tx_pin, 1'b1)
		t_good();
		t_var();
		t_other();
		t_bad();
		t_noidle();
		t_comm();
		t_missed();
		report_and_stop();
	end
endmodule : tb
